// [design/adc_conv_ctrl.sv]
`timescale 1ns/1ns
`include "adc_ctrl_params.svh"
module adc_conv_ctrl #(
  parameter int SETTLE_CYCLES = `SETTLE_CYC, // reference settling, clocks
  parameter int CONV_CYCLES   = `CONV_CYC    // conversion length, clocks
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    convert_strobe_n,
  input  wire logic                    sck_in,
  input  wire logic                    iface_mode_sel,
  input  wire logic                    supply_ok,
  input  wire logic [`RESULT_BITS-1:0] sample_data,
  output logic                         sample_start,
  output logic                         conv_busy,
  output logic                         result_valid,
  output logic                         sdo_p,
  output logic                         sdo_n,
  output logic [1:0]                   power_state,
  output logic                         nap_active,
  output logic                         sleep_active,
  output logic                         ref_ready
);

  localparam int SW = $clog2(SETTLE_CYCLES + 1);
  localparam int BW = $clog2(`RESULT_BITS + 1);

  // refuse settings the counters cannot serve
  if (SETTLE_CYCLES < 1 || CONV_CYCLES < 1)
  begin : g_chk
    $error("adc_conv_ctrl: cycle counts must be at least 1");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic cnv_level;                          // synced strobe, unused level
  logic cnv_rise;                           // end of a convert pulse
  logic cnv_fall;                           // start of a convert pulse
  logic sck_level;                          // synced serial clock
  logic sck_rise;                           // wake edge
  logic sck_fall;                           // shift edge
  logic mode_level;                         // synced mode pin
  logic supply_level;                       // synced supply monitor
  logic supply_fail;                        // supply below threshold

  // strobe idles high, so reset its chain high to avoid a false edge
  edge_sync #(.RESET_LEVEL(1'b1)) u_cnv_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (convert_strobe_n),
    .level   (cnv_level),
    .rise    (cnv_rise),
    .fall    (cnv_fall)
  );

  // serial clock is sampled, not used as a clock
  edge_sync #(.RESET_LEVEL(1'b0)) u_sck_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (sck_in),
    .level   (sck_level),
    .rise    (sck_rise),
    .fall    (sck_fall)
  );

  // interface mode pin
  edge_sync #(.RESET_LEVEL(1'b0)) u_mode_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (iface_mode_sel),
    .level   (mode_level),
    .rise    (),
    .fall    ()
  );

  // supply monitor, treated as failed until seen good
  edge_sync #(.RESET_LEVEL(1'b0)) u_sup_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (supply_ok),
    .level   (supply_level),
    .rise    (),
    .fall    ()
  );

  assign supply_fail = ~supply_level;

  // ****************************************************************
  // conversion timing
  // ****************************************************************
  logic conv_start;                         // falling strobe edge, supply good
  logic conv_done;                          // conversion finished

  assign conv_start = cnv_fall & supply_level;

  // internally timed conversion, no host clock involved
  conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (conv_start),
    .abort   (supply_fail),
    .busy    (conv_busy),
    .done    (conv_done)
  );

  // ****************************************************************
  // power state and pulse counting
  // ****************************************************************
  adc_ctrl_pkg::power_state_t state_ff;     // current power state
  adc_ctrl_pkg::power_state_t nxt_state;
  logic [2:0]                 pulse_cnt_ff; // strobes since last clock edge
  logic [2:0]                 nxt_pulse_cnt;
  logic                       lvds_mode;    // lvds interface chosen
  logic                       sleep_exit;   // leaving sleep this cycle

  assign lvds_mode = (mode_level == `MODE_LVDS_LEVEL);

  // next power state
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_pulse_cnt = pulse_cnt_ff;
    sleep_exit    = 1'b0;
    if (supply_fail)
    begin
      // supply loss restarts from full power
      nxt_state     = adc_ctrl_pkg::PWR_OPER;
      nxt_pulse_cnt = 3'h0;
    end
    else if (sck_rise)
    begin
      unique case (state_ff)
        adc_ctrl_pkg::PWR_OPER:
        begin
          // clock activity keeps the part awake
          nxt_pulse_cnt = 3'h0;
        end
        adc_ctrl_pkg::PWR_NAP:
        begin
          // one rising clock edge ends nap
          nxt_state     = adc_ctrl_pkg::PWR_OPER;
          nxt_pulse_cnt = 3'h0;
        end
        adc_ctrl_pkg::PWR_SLEEP:
        begin
          // clock wake only in cmos mode
          if (!lvds_mode)
          begin
            nxt_state     = adc_ctrl_pkg::PWR_OPER;
            nxt_pulse_cnt = 3'h0;
            sleep_exit    = 1'b1;
          end
        end
        default:
        begin
          // illegal code recovers to full power
          nxt_state     = adc_ctrl_pkg::PWR_OPER;
          nxt_pulse_cnt = 3'h0;
        end
      endcase
    end
    else if (cnv_rise)
    begin
      // count strobes while the serial clock stays idle
      nxt_pulse_cnt = pulse_cnt_ff + 3'h1;
      unique case (state_ff)
        adc_ctrl_pkg::PWR_OPER:
        begin
          // second rising strobe edge enters nap
          if (nxt_pulse_cnt == `NAP_PULSE_CNT)
          begin
            nxt_state = adc_ctrl_pkg::PWR_NAP;
          end
        end
        adc_ctrl_pkg::PWR_NAP:
        begin
          // two more strobes enter sleep
          if (nxt_pulse_cnt == `SLEEP_PULSE_CNT)
          begin
            nxt_state = adc_ctrl_pkg::PWR_SLEEP;
          end
        end
        adc_ctrl_pkg::PWR_SLEEP:
        begin
          // fifth strobe wakes in either mode, then cycle restarts
          if (nxt_pulse_cnt == `WAKE_PULSE_CNT)
          begin
            nxt_state     = adc_ctrl_pkg::PWR_OPER;
            nxt_pulse_cnt = 3'h0;
            sleep_exit    = 1'b1;
          end
        end
        default:
        begin
          nxt_state     = adc_ctrl_pkg::PWR_OPER;
          nxt_pulse_cnt = 3'h0;
        end
      endcase
    end
  end

  // register stage of the power state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff     <= adc_ctrl_pkg::PWR_OPER;
      pulse_cnt_ff <= 3'h0;
    end
    else
    begin
      state_ff     <= nxt_state;
      pulse_cnt_ff <= nxt_pulse_cnt;
    end
  end

  assign power_state  = state_ff;
  assign nap_active   = (state_ff == adc_ctrl_pkg::PWR_NAP);
  assign sleep_active = (state_ff == adc_ctrl_pkg::PWR_SLEEP);

  // ****************************************************************
  // reference settling after reset, supply loss or sleep
  // ****************************************************************
  logic [SW-1:0] settle_cnt_ff;             // clocks since restart
  logic          ready_ff;                  // settling complete
  logic [SW-1:0] nxt_settle_cnt;
  logic          nxt_ready;

  // next settling values
  always_comb
  begin
    nxt_settle_cnt = settle_cnt_ff;
    nxt_ready      = ready_ff;
    if (supply_fail || sleep_exit)
    begin
      // restart the wait
      nxt_settle_cnt = '0;
      nxt_ready      = 1'b0;
    end
    else if (settle_cnt_ff != SW'(SETTLE_CYCLES))
    begin
      nxt_settle_cnt = settle_cnt_ff + 1'b1;
      nxt_ready      = (nxt_settle_cnt == SW'(SETTLE_CYCLES));
    end
  end

  // register stage of the settling timer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_cnt_ff <= '0;
      ready_ff      <= 1'b0;
    end
    else
    begin
      settle_cnt_ff <= nxt_settle_cnt;
      ready_ff      <= nxt_ready;
    end
  end

  assign ref_ready = ready_ff;

  // ****************************************************************
  // result capture and serial readout
  // ****************************************************************
  logic [`RESULT_BITS-1:0] shift_ff;        // bits still to send
  logic [BW-1:0]           bit_cnt_ff;      // bits sent so far
  logic                    sdo_ff;          // current data bit
  logic                    sdo_p_ff;        // true output
  logic                    sdo_n_ff;        // complement, lvds only
  logic                    valid_ff;        // result trusted
  logic                    trust_ff;        // settled when conversion began
  logic                    start_ff;        // core sampling pulse
  logic [`RESULT_BITS-1:0] nxt_shift;
  logic [BW-1:0]           nxt_bit_cnt;
  logic                    nxt_sdo;
  logic                    nxt_valid;
  logic                    nxt_trust;

  // next readout values
  always_comb
  begin
    nxt_shift   = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_sdo     = sdo_ff;
    nxt_valid   = valid_ff;
    nxt_trust   = trust_ff;
    if (supply_fail)
    begin
      nxt_shift   = '0;
      nxt_bit_cnt = BW'(`RESULT_BITS);
      nxt_sdo     = 1'b0;
      nxt_valid   = 1'b0;
      nxt_trust   = 1'b0;
    end
    else if (conv_done)
    begin
      // this conversion's own result, no pipeline
      nxt_shift   = sample_data;
      nxt_bit_cnt = '0;
      nxt_sdo     = 1'b0;
      nxt_valid   = trust_ff;
      nxt_trust   = conv_start ? ready_ff : trust_ff;  // strobe landing on the load is still judged
    end
    else if (conv_start)
    begin
      // new conversion drops the old result
      nxt_valid = 1'b0;
      nxt_trust = ready_ff;
    end
    else if (sck_fall && bit_cnt_ff != BW'(`RESULT_BITS))
    begin
      // msb first, one bit per falling edge
      nxt_sdo     = shift_ff[`RESULT_BITS-1];
      nxt_shift   = {shift_ff[`RESULT_BITS-2:0], 1'b0};
      nxt_bit_cnt = bit_cnt_ff + 1'b1;
    end
    else if (sck_fall)
    begin
      // past the last bit, line returns low
      nxt_sdo = 1'b0;
    end
  end

  // register stage of the readout
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff   <= '0;
      bit_cnt_ff <= BW'(`RESULT_BITS);
      sdo_ff     <= 1'b0;
      sdo_p_ff   <= 1'b0;
      sdo_n_ff   <= 1'b0;
      valid_ff   <= 1'b0;
      trust_ff   <= 1'b0;
      start_ff   <= 1'b0;
    end
    else
    begin
      shift_ff   <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      sdo_ff     <= nxt_sdo;
      sdo_p_ff   <= nxt_sdo;
      sdo_n_ff   <= lvds_mode & ~nxt_sdo;
      valid_ff   <= nxt_valid;
      trust_ff   <= nxt_trust;
      start_ff   <= conv_start;
    end
  end

  assign sdo_p        = sdo_p_ff;
  assign sdo_n        = sdo_n_ff;
  assign result_valid = valid_ff;
  assign sample_start = start_ff;

endmodule

// [design/adc_ctrl_params.svh]
// Contract
// - convert strobe falling edge starts timed conversion
// - serial clock falling edge presents next bit, MSB first
// - supply drop resets, recovery reinitialises
// - two pulses, clock idle, enter nap
// - serial clock rising edge leaves nap
// - two more pulses move nap to sleep
// - cmos mode: clock rising edge leaves sleep
// - lvds: fifth pulse leaves sleep
// - fifth pulse also leaves sleep in cmos
// - idle clock: states cycle on pulses forever
// - mode pin selects cmos or lvds
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define REF_CLK_MHZ     25
`define CONV_TIME_NS    300
`define CONV_CYC        ((`CONV_TIME_NS * `REF_CLK_MHZ + 999) / 1000)
`define SETTLE_TIME_MS  10
`define SETTLE_CYC      (`SETTLE_TIME_MS * 1000 * `REF_CLK_MHZ)

// ****************************************************************
// result and power sequencing
// ****************************************************************
`define RESULT_BITS     16
`define NAP_PULSE_CNT   3'h2
`define SLEEP_PULSE_CNT 3'h4
`define WAKE_PULSE_CNT  3'h5
`define MODE_LVDS_LEVEL 1'b1

`endif

// [design/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

  // ****************************************************************
  // power states of the converter
  // ****************************************************************
  typedef enum logic [1:0] {
    PWR_OPER,
    PWR_NAP,
    PWR_SLEEP
  } power_state_t;

endpackage

// [design/edge_sync.sv]
`timescale 1ns/1ns
module edge_sync #(
  parameter logic RESET_LEVEL = 1'b0        // idle level of the pin
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,                 // asynchronous pin
  output logic      level,                  // synchronised level
  output logic      rise,                   // one-cycle pulse
  output logic      fall                    // one-cycle pulse
);

  // ****************************************************************
  // two-stage synchroniser plus edge history
  // ****************************************************************
  logic meta_ff;                            // first stage, read only by sync_ff
  logic sync_ff;                            // second stage
  logic prev_ff;                            // previous synced level
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  // next values of the chain
  always_comb
  begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  // register stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RESET_LEVEL;
      sync_ff <= RESET_LEVEL;
      prev_ff <= RESET_LEVEL;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
  assign fall  = ~sync_ff & prev_ff;

endmodule

// [design/conv_timer.sv]
`timescale 1ns/1ns
`include "adc_ctrl_params.svh"
module conv_timer #(
  parameter int CYCLES = `CONV_CYC          // conversion length in clocks
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic start,                  // begin a conversion
  input  wire logic abort,                  // supply lost
  output logic      busy,                   // conversion running
  output logic      done                    // one-cycle end pulse
);

  localparam int CW = $clog2(CYCLES + 1);

  // refuse a zero-length conversion
  if (CYCLES < 1)
  begin : g_chk
    $error("conv_timer: CYCLES must be at least 1");
  end

  // ****************************************************************
  // down counter timing the conversion internally
  // ****************************************************************
  logic [CW-1:0] cnt_ff;                    // cycles left
  logic          done_ff;                   // end pulse
  logic [CW-1:0] nxt_cnt;
  logic          nxt_done;

  // next counter value
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (abort)
    begin
      nxt_cnt = '0;
    end
    else if (start)
    begin
      // restart, even over a running conversion
      nxt_cnt = CW'(CYCLES);
    end
    else if (cnt_ff != '0)
    begin
      nxt_cnt  = cnt_ff - 1'b1;
      nxt_done = (cnt_ff == CW'(1));
    end
  end

  // register stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;

endmodule

// [bench/adc_conv_ctrl_chk.sv]
`timescale 1ns/1ns
// ****************************************************************
// port checker for the conversion and power control
// ****************************************************************
module adc_conv_ctrl_chk #(
  parameter int SETTLE_CYCLES = 50,     // settling length, clocks
  parameter int CONV_CYCLES   = 8       // conversion length, clocks
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       iface_mode_sel,
  input wire logic       supply_ok,
  input wire logic       sample_start,
  input wire logic       conv_busy,
  input wire logic       result_valid,
  input wire logic       sdo_p,
  input wire logic       sdo_n,
  input wire logic [1:0] power_state,
  input wire logic       nap_active,
  input wire logic       sleep_active,
  input wire logic       ref_ready
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // conversion
  // ****************************************************************
  // busy for the full conversion length (8 clocks in this build)
  a_busy_length: assert property (sample_start |-> conv_busy [*8])
    else $error("conversion busy shorter than its length");
  a_start_pulse: assert property (sample_start |=> !sample_start)
    else $error("start pulse longer than one clock");
  // trusted conversion ends with its own result loaded
  // ready judged as the strobe was taken (9 clocks back), conversion ran full length
  a_result_load: assert property ($fell(conv_busy) && $past(sample_start, 8) && $past(ref_ready, 9)
                                  && supply_ok |-> ##[0:2] result_valid)
    else $error("result not loaded after conversion end");

  // ****************************************************************
  // serial output and mode
  // ****************************************************************
  a_lvds_pair: assert property (iface_mode_sel && $past(iface_mode_sel, 4) && $past(rst_n, 4)
                                |-> sdo_n == !sdo_p)
    else $error("differential output not complementary");
  a_cmos_quiet: assert property (!iface_mode_sel && !$past(iface_mode_sel, 4) |-> !sdo_n)
    else $error("negative output driven in single-ended mode");

  // ****************************************************************
  // power states
  // ****************************************************************
  a_state_decode: assert property (nap_active == (power_state == 2'h1)
                                   && sleep_active == (power_state == 2'h2))
    else $error("power flags disagree with state");
  // only oper to nap and nap to sleep go upward
  a_state_step: assert property ($changed(power_state) && power_state != 2'h0
                                 |-> power_state == $past(power_state) + 2'h1)
    else $error("illegal power state step");
  a_sleep_exit: assert property ($fell(sleep_active) && supply_ok |-> ##[0:2] !ref_ready)
    else $error("settling not restarted on sleep exit");
  a_ready_settle: assert property ($rose(ref_ready) |-> $past(supply_ok, 40))
    else $error("ready rose without settled supply");
endmodule

// [bench/host_model.sv]
`timescale 1ns/1ns
// ****************************************************************
// host side: drives convert strobe and serial clock pins
// ****************************************************************
module host_model (
  input  wire logic ref_clk,            // bench clock, pins move on its rising edge
  output logic      convert_strobe_n,   // active-low convert strobe
  output logic      sck_in              // serial clock, idle low
);
  // both pins idle at time zero
  initial
  begin
    convert_strobe_n = 1'b1;
    sck_in           = 1'b0;
  end

  // pulse low 4 clocks, then high long enough for the conversion, clock still
  task automatic convert_pulse();
  begin
    @(posedge ref_clk);
    convert_strobe_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    convert_strobe_n <= 1'b1;
    repeat (7) @(posedge ref_clk);
    #7;
  end
  endtask

  // one 320 ns clock period, rate scaled to the sampling clock; returns once the bit settled
  task automatic sck_pulse();
  begin
    @(posedge ref_clk);
    sck_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sck_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #7;
  end
  endtask
endmodule

// [bench/adc_conv_ctrl_test.sv]
`timescale 1ns/1ns
`include "adc_ctrl_params.svh"
// ****************************************************************
// self-checking bench for the conversion and power control
// ****************************************************************
module adc_conv_ctrl_test;
  typedef struct {logic [2:0] sel; logic [1:0] val;} note_t; // one expected result
  logic                    ref_clk;          // 25 MHz clock
  logic                    rst_n;            // async reset
  logic                    convert_strobe_n; // from host model
  logic                    sck_in;           // from host model
  logic                    iface_mode_sel;   // 1 lvds, 0 cmos
  logic                    supply_ok;        // supply in range
  logic [`RESULT_BITS-1:0] sample_data;      // converter core result
  logic                    sample_start;
  logic                    conv_busy;
  logic                    result_valid;
  logic                    sdo_p;
  logic                    sdo_n;
  logic [1:0]              power_state;
  logic                    nap_active;
  logic                    sleep_active;
  logic                    ref_ready;
  note_t                   exp_q[$];         // pending expectations
  note_t                   e;                // note under comparison
  logic [1:0]              seen;             // observed value
  logic                    b;                // expected serial bit
  logic [1:0]              ps_tbl[5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2}; // state after pulse k mod 5
  string                   nm[7] = '{"sdo_p", "sdo_n", "power_state", "result_valid", "ref_ready",
                                     "sleep_nap", "start_busy"};
  int                      num_errors = 0;
  int                      num_checks = 0;
  event                    chk_ev;           // wakes the monitor

  host_model host (.ref_clk, .convert_strobe_n, .sck_in);
  adc_conv_ctrl #(.SETTLE_CYCLES(50), .CONV_CYCLES(8)) uut (
    .ref_clk, .rst_n, .convert_strobe_n, .sck_in, .iface_mode_sel, .supply_ok, .sample_data,
    .sample_start, .conv_busy, .result_valid, .sdo_p, .sdo_n, .power_state, .nap_active,
    .sleep_active, .ref_ready);

  // ****************************************************************
  // clock, tasks
  // ****************************************************************
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // wait n clocks, land 7 ns after the edge
  task automatic cyc(input int n);
  begin
    repeat (n) @(posedge ref_clk);
    #7;
  end
  endtask

  // queue an expectation and wake the monitor
  task automatic note(input logic [2:0] sel, input logic [1:0] val);
  begin
    exp_q.push_back('{sel, val});
    -> chk_ev;
  end
  endtask

  // bounded wait for settling, then confirm it
  task automatic wait_ready();
  begin
    for (int i = 0; i < 200 && ref_ready !== 1'b1; i++)
      cyc(1);
    note(3'h4, 2'h1);
  end
  endtask

  task automatic wrap_up();
  begin
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // ****************************************************************
  // monitor: compares outputs against the oldest notes
  // ****************************************************************
  always
  begin
    @(chk_ev);
    while (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      case (e.sel)
        3'h0:    seen = {1'b0, sdo_p};
        3'h1:    seen = {1'b0, sdo_n};
        3'h2:    seen = power_state;
        3'h3:    seen = {1'b0, result_valid};
        3'h5:    seen = {sleep_active, nap_active};
        3'h6:    seen = {sample_start, conv_busy};
        default: seen = {1'b0, ref_ready};
      endcase
      num_checks++;
      if (seen !== e.val)
      begin
        num_errors++;
        $display("unexpected %s: expected %0h, seen %0h", nm[e.sel], e.val, seen);
      end
    end
  end

  // hang guard
  initial
  begin
    #400000;
    num_errors++;
    wrap_up();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(7));
    rst_n          = 1'b0;
    supply_ok      = 1'b1;
    iface_mode_sel = 1'b0;
    sample_data    = 16'h0000;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(1);
    // conversion before settling is not trusted
    host.convert_pulse();
    cyc(8);
    note(3'h3, 2'h0);
    wait_ready();
    // readout, cmos then lvds, one extra clock past the word
    for (int m = 0; m < 2; m++)
    begin
      @(posedge ref_clk);
      iface_mode_sel <= m[0];
      sample_data    <= 16'($urandom);
      cyc(4);
      host.convert_pulse();
      cyc(4);
      note(3'h3, 2'h1);
      note(3'h6, 2'h0);
      for (int i = 15; i >= -1; i--)
      begin
        host.sck_pulse();
        b = (i >= 0) ? sample_data[i] : 1'b0;
        note(3'h0, {1'b0, b});
        note(3'h1, {1'b0, m[0] & ~b});
      end
    end
    // power stepping, lvds then cmos
    for (int m = 1; m >= 0; m--)
    begin
      @(posedge ref_clk);
      iface_mode_sel <= m[0];
      cyc(4);
      host.sck_pulse();
      for (int k = 1; k <= 10; k++)
      begin
        host.convert_pulse();
        note(3'h2, ps_tbl[k % 5]);
        note(3'h5, ps_tbl[k % 5]);
      end
      wait_ready();
      repeat (2) host.convert_pulse();
      host.sck_pulse();
      note(3'h2, 2'h0);
      repeat (4) host.convert_pulse();
      note(3'h2, 2'h2);
      note(3'h5, 2'h2);
      // clock wakes sleep only in cmos
      host.sck_pulse();
      note(3'h2, {m[0], 1'b0});
      if (m == 1)
        host.convert_pulse();
      note(3'h2, 2'h0);
      note(3'h4, 2'h0);
      wait_ready();
    end
    // supply loss from nap forces oper and clears trust
    repeat (2) host.convert_pulse();
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    cyc(4);
    note(3'h2, 2'h0);
    note(3'h4, 2'h0);
    note(3'h3, 2'h0);
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    cyc(1);
    wait_ready();
    cyc(1);
    wrap_up();
  end
endmodule

bind adc_conv_ctrl adc_conv_ctrl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES), .CONV_CYCLES(CONV_CYCLES)) chk (
  .ref_clk, .rst_n, .iface_mode_sel, .supply_ok, .sample_start, .conv_busy, .result_valid,
  .sdo_p, .sdo_n, .power_state, .nap_active, .sleep_active, .ref_ready);
